// ### pst_pkg.sv
// Shared constants, register map and helpers of the packet self test engine.
package pst_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
  localparam logic [4:0] REG_COUNT_VIEW = 5'h18;
  localparam logic [4:0] REG_CFG_ONE = 5'h19;
  localparam logic [4:0] REG_CFG_TWO = 5'h1a;

  // Basic control register fields.
  localparam int BC_LOOPBACK = 14;
  localparam logic BC_LOOPBACK_RESET = 1'b0;

  // First configuration register fields.
  localparam int C1_CNT_TYPE = 15;
  localparam int C1_CNT_CLEAR = 14;
  localparam int C1_LEN_LONG = 13;
  localparam int C1_GAP_LONG = 12;
  localparam int C1_TX_ENABLE = 11;
  localparam int C1_PRBS_SEL = 10;
  localparam int C1_PATTERN_LSB = 0;
  localparam int C1_PATTERN_W = 8;
  localparam logic [15:0] C1_RESET = 16'h0000;

  // Second configuration register fields.
  localparam int C2_CNT_ENABLE = 15;
  localparam int C2_CNT_UPPER = 14;
  localparam int C2_COUNT_LSB = 11;
  localparam int C2_COUNT_W = 3;
  localparam logic [15:0] C2_RESET = 16'h0000;

  localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;

  // ==========================================================================
  // Frame timing
  // ==========================================================================
  localparam logic [10:0] LEN_SHORT_BYTES = 11'd60;
  localparam logic [10:0] LEN_LONG_BYTES = 11'd1514;
  // Gaps are counted in byte clocks of the gigabit data clock.
  localparam int LINK_PERIOD_PS = 8000;
  localparam int GAP_LONG_PS = 9600000;
  localparam int GAP_SHORT_PS = 96000;
  localparam int GAP_LONG_CYC = (GAP_LONG_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int GAP_SHORT_CYC = (GAP_SHORT_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam logic [10:0] GAP_LONG_CNT = GAP_LONG_CYC[10:0];
  localparam logic [10:0] GAP_SHORT_CNT = GAP_SHORT_CYC[10:0];

  localparam logic [8:0] PRBS_SEED = 9'h1ff;

  // Frame count per code; zero means run until software stops it.
  function automatic logic [23:0] frameTarget(input logic [2:0] code);
    logic [23:0] t;
    t = 24'h000000;
    unique case (code)
      3'h0: t = 24'd0;
      3'h1: t = 24'd1;
      3'h2: t = 24'd10;
      3'h3: t = 24'd100;
      3'h4: t = 24'd1000;
      3'h5: t = 24'd10000;
      3'h6: t = 24'd100000;
      3'h7: t = 24'd10000000;
    endcase
    return t;
  endfunction

  // Eight steps of x^9 + x^5 + 1; returns {byte, next state}, first bit in the msb.
  function automatic logic [16:0] prbsByte(input logic [8:0] seed);
    logic [8:0] s;
    logic [7:0] b;
    logic fb;
    s = seed;
    b = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      fb = s[8] ^ s[4];
      s = {s[7:0], fb};
      b = {b[6:0], fb};
    end
    return {b, s};
  endfunction

endpackage

// ### pst_gen_if.sv
// Control and data bundle between the register side and the frame generator.
`timescale 1ns/1ps
interface pst_gen_if;
  logic run;
  logic lenLong;
  logic gapLong;
  logic prbsSel;
  logic [7:0] pattern;
  logic [2:0] countCode;
  logic doneToggle;
  logic busy;
  logic [7:0] txData;
  logic txValid;

  modport ctrl (
    output run,
    output lenLong,
    output gapLong,
    output prbsSel,
    output pattern,
    output countCode,
    input doneToggle,
    input busy,
    input txData,
    input txValid
  );

  modport gen (
    input run,
    input lenLong,
    input gapLong,
    input prbsSel,
    input pattern,
    input countCode,
    output doneToggle,
    output busy,
    output txData,
    output txValid
  );
endinterface

// ### pst_frame_gen.sv
// Test frame generator running on the link data clock.
`timescale 1ns/1ps
module pst_frame_gen (
  input wire logic linkClk,
  input wire logic nrst,
  pst_gen_if.gen genPort
);

  typedef enum logic [1:0] {GEN_IDLE, GEN_DATA, GEN_GAP, GEN_DONE} pst_gen_state_t;

  pst_gen_state_t state_q;
  logic [10:0] byteCnt_q;
  logic [10:0] gapCnt_q;
  logic [23:0] sentCnt_q;
  logic [23:0] target_q;
  logic [10:0] lastByte_q;
  logic [10:0] lastGap_q;
  logic prbs_q;
  logic [7:0] pattern_q;
  logic [8:0] lfsr_q;
  logic [16:0] prbsNext;
  logic [7:0] nextByte;

  assign prbsNext = pst_pkg::prbsByte(lfsr_q);
  assign nextByte = prbs_q ? prbsNext[16:9] : pattern_q;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Settings are latched at the start of a run, so a change while running
  // cannot tear a frame.
  always_ff @(posedge linkClk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= GEN_IDLE;
      byteCnt_q <= 11'd0;
      gapCnt_q <= 11'd0;
      sentCnt_q <= 24'd0;
      target_q <= 24'd0;
      lastByte_q <= 11'd0;
      lastGap_q <= 11'd0;
      prbs_q <= 1'b0;
      pattern_q <= 8'h00;
      genPort.doneToggle <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        GEN_IDLE:
        begin
          if (genPort.run)
          begin
            state_q <= GEN_DATA;
            byteCnt_q <= 11'd0;
            sentCnt_q <= 24'd0;
            target_q <= pst_pkg::frameTarget(genPort.countCode);
            lastByte_q <= (genPort.lenLong ? pst_pkg::LEN_LONG_BYTES
                                           : pst_pkg::LEN_SHORT_BYTES) - 11'd1;
            lastGap_q <= (genPort.gapLong ? pst_pkg::GAP_LONG_CNT
                                          : pst_pkg::GAP_SHORT_CNT) - 11'd1;
            prbs_q <= genPort.prbsSel;
            pattern_q <= genPort.pattern;
          end
        end
        GEN_DATA:
        begin
          byteCnt_q <= byteCnt_q + 11'd1;
          if (byteCnt_q == lastByte_q)
          begin
            state_q <= GEN_GAP;
            gapCnt_q <= 11'd0;
            sentCnt_q <= sentCnt_q + 24'd1;
          end
        end
        GEN_GAP:
        begin
          gapCnt_q <= gapCnt_q + 11'd1;
          if (gapCnt_q == lastGap_q)
          begin
            if (target_q != 24'd0 && sentCnt_q == target_q)
            begin
              state_q <= GEN_DONE;
              genPort.doneToggle <= ~genPort.doneToggle;
            end
            else if (genPort.run)
            begin
              state_q <= GEN_DATA;
              byteCnt_q <= 11'd0;
            end
            else
            begin
              state_q <= GEN_IDLE;
            end
          end
        end
        GEN_DONE:
        begin
          if (!genPort.run)
          begin
            state_q <= GEN_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Payload
  // ==========================================================================
  always_ff @(posedge linkClk or negedge nrst)
  begin
    if (!nrst)
    begin
      lfsr_q <= pst_pkg::PRBS_SEED;
      genPort.txData <= 8'h00;
      genPort.txValid <= 1'b0;
      genPort.busy <= 1'b0;
    end
    else
    begin
      genPort.busy <= (state_q != GEN_IDLE) || genPort.run;
      genPort.txValid <= (state_q == GEN_DATA);
      genPort.txData <= (state_q == GEN_DATA) ? nextByte : 8'h00;
      if (state_q == GEN_DATA && prbs_q)
      begin
        lfsr_q <= prbsNext[8:0];
      end
    end
  end

endmodule

// ### pst_self_test.sv
// Packet self test engine: management registers, receive counter and link data path.
`timescale 1ns/1ps
module pst_self_test (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic linkClk,
  input wire logic [4:0] mgmtAddr,
  input wire logic mgmtWrEn,
  input wire logic [15:0] mgmtWrData,
  input wire logic mgmtRdEn,
  output logic [15:0] mgmtRdData,
  input wire logic [7:0] macTxd,
  input wire logic macTxEn,
  input wire logic macTxEr,
  output logic [7:0] macRxd,
  output logic macRxDv,
  output logic macRxEr,
  output logic [7:0] lineTxd,
  output logic lineTxEn,
  output logic lineTxEr,
  input wire logic [7:0] lineRxd,
  input wire logic lineRxDv,
  input wire logic lineRxEr
);

  // ==========================================================================
  // Management registers (system clock)
  // ==========================================================================
  logic loopback_q, cntType_q, lenLong_q, gapLong_q, txEnable_q, prbsSel_q;
  logic [7:0] pattern_q;
  logic cntEnable_q, cntUpper_q;
  logic [2:0] countCode_q;
  logic [31:0] counter_q;
  logic [15:0] cfgOneView, cfgTwoView, readMux;
  logic wrBasic, wrCfgOne, wrCfgTwo, clearPulse;
  logic doneSeen, pktSeen, errSeen, countEvent;

  assign wrBasic = mgmtWrEn && (mgmtAddr == pst_pkg::REG_BASIC_CTRL);
  assign wrCfgOne = mgmtWrEn && (mgmtAddr == pst_pkg::REG_CFG_ONE);
  assign wrCfgTwo = mgmtWrEn && (mgmtAddr == pst_pkg::REG_CFG_TWO);
  assign clearPulse = wrCfgOne && mgmtWrData[pst_pkg::C1_CNT_CLEAR];

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      loopback_q <= pst_pkg::BC_LOOPBACK_RESET;
    end
    else if (wrBasic)
    begin
      loopback_q <= mgmtWrData[pst_pkg::BC_LOOPBACK];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cntType_q <= pst_pkg::C1_RESET[pst_pkg::C1_CNT_TYPE];
      lenLong_q <= pst_pkg::C1_RESET[pst_pkg::C1_LEN_LONG];
      gapLong_q <= pst_pkg::C1_RESET[pst_pkg::C1_GAP_LONG];
      prbsSel_q <= pst_pkg::C1_RESET[pst_pkg::C1_PRBS_SEL];
      pattern_q <= pst_pkg::C1_RESET[pst_pkg::C1_PATTERN_LSB +: pst_pkg::C1_PATTERN_W];
    end
    else if (wrCfgOne)
    begin
      cntType_q <= mgmtWrData[pst_pkg::C1_CNT_TYPE];
      lenLong_q <= mgmtWrData[pst_pkg::C1_LEN_LONG];
      gapLong_q <= mgmtWrData[pst_pkg::C1_GAP_LONG];
      prbsSel_q <= mgmtWrData[pst_pkg::C1_PRBS_SEL];
      pattern_q <= mgmtWrData[pst_pkg::C1_PATTERN_LSB +: pst_pkg::C1_PATTERN_W];
    end
  end

  // A software write in the same cycle as the completion wins; the generator
  // then waits in GEN_DONE until the enable is cleared, so no new run starts.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txEnable_q <= pst_pkg::C1_RESET[pst_pkg::C1_TX_ENABLE];
    end
    else if (wrCfgOne)
    begin
      txEnable_q <= mgmtWrData[pst_pkg::C1_TX_ENABLE];
    end
    else if (doneSeen)
    begin
      txEnable_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cntEnable_q <= pst_pkg::C2_RESET[pst_pkg::C2_CNT_ENABLE];
      cntUpper_q <= pst_pkg::C2_RESET[pst_pkg::C2_CNT_UPPER];
      countCode_q <= pst_pkg::C2_RESET[pst_pkg::C2_COUNT_LSB +: pst_pkg::C2_COUNT_W];
    end
    else if (wrCfgTwo)
    begin
      cntEnable_q <= mgmtWrData[pst_pkg::C2_CNT_ENABLE];
      cntUpper_q <= mgmtWrData[pst_pkg::C2_CNT_UPPER];
      countCode_q <= mgmtWrData[pst_pkg::C2_COUNT_LSB +: pst_pkg::C2_COUNT_W];
    end
  end

  // ==========================================================================
  // Receive counter
  // ==========================================================================
  assign countEvent = cntEnable_q && (cntType_q ? errSeen : pktSeen);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      counter_q <= pst_pkg::COUNTER_RESET;
    end
    else if (clearPulse)
    begin
      counter_q <= pst_pkg::COUNTER_RESET;
    end
    else if (countEvent)
    begin
      counter_q <= counter_q + 32'd1;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  // The clear bit is a command and always reads back as zero.
  always_comb
  begin
    cfgOneView = 16'h0000;
    cfgOneView[pst_pkg::C1_CNT_TYPE] = cntType_q;
    cfgOneView[pst_pkg::C1_LEN_LONG] = lenLong_q;
    cfgOneView[pst_pkg::C1_GAP_LONG] = gapLong_q;
    cfgOneView[pst_pkg::C1_TX_ENABLE] = txEnable_q;
    cfgOneView[pst_pkg::C1_PRBS_SEL] = prbsSel_q;
    cfgOneView[pst_pkg::C1_PATTERN_LSB +: pst_pkg::C1_PATTERN_W] = pattern_q;
    cfgTwoView = 16'h0000;
    cfgTwoView[pst_pkg::C2_CNT_ENABLE] = cntEnable_q;
    cfgTwoView[pst_pkg::C2_CNT_UPPER] = cntUpper_q;
    cfgTwoView[pst_pkg::C2_COUNT_LSB +: pst_pkg::C2_COUNT_W] = countCode_q;
  end

  always_comb
  begin
    unique case (mgmtAddr)
      pst_pkg::REG_BASIC_CTRL: readMux = {1'b0, loopback_q, 14'h0000};
      pst_pkg::REG_COUNT_VIEW: readMux = cntUpper_q ? counter_q[31:16]
                                                    : counter_q[15:0];
      pst_pkg::REG_CFG_ONE: readMux = cfgOneView;
      pst_pkg::REG_CFG_TWO: readMux = cfgTwoView;
      default: readMux = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mgmtRdData <= 16'h0000;
    end
    else if (mgmtRdEn)
    begin
      mgmtRdData <= readMux;
    end
  end

  // ==========================================================================
  // Crossing from the system clock to the link clock
  // ==========================================================================
  // Only the enable and loopback bits change while the generator runs; the
  // remaining settings are latched at the start of a run and must be held
  // stable by software from the enabling write onward.
  localparam int CTL_W = 16;
  logic [CTL_W-1:0] ctlSys;
  logic [CTL_W-1:0] ctlMeta_q;
  logic [CTL_W-1:0] ctlLink_q;
  logic runHold_q;

  assign ctlSys = {loopback_q, txEnable_q, lenLong_q, gapLong_q, prbsSel_q,
                   countCode_q, pattern_q};

  always_ff @(posedge linkClk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctlMeta_q <= '0;
      ctlLink_q <= '0;
      runHold_q <= 1'b0;
    end
    else
    begin
      ctlMeta_q <= ctlSys;
      ctlLink_q <= ctlMeta_q;
      runHold_q <= ctlLink_q[14];
    end
  end

  pst_gen_if genBus ();

  assign genBus.pattern = ctlLink_q[7:0];
  assign genBus.countCode = ctlLink_q[10:8];
  assign genBus.prbsSel = ctlLink_q[11];
  assign genBus.gapLong = ctlLink_q[12];
  assign genBus.lenLong = ctlLink_q[13];
  // The settings cross as a plain bus, so one bit may land a link clock after
  // the enable; the run waits until the enable has stood for two link clocks,
  // by which time every setting written with it has settled.
  assign genBus.run = ctlLink_q[14] && runHold_q;

  logic loopLink;
  assign loopLink = ctlLink_q[15];

  pst_frame_gen frameGen (
    .linkClk(linkClk),
    .nrst(nrst),
    .genPort(genBus)
  );

  // ==========================================================================
  // Link data path
  // ==========================================================================
  // The transmit source switches to the generator for the whole run, and the
  // monitor below only observes, so the receive path is a plain register stage.
  logic [7:0] srcTxd;
  logic srcTxEn, srcTxEr;

  always_comb
  begin
    if (genBus.busy)
    begin
      srcTxd = genBus.txData;
      srcTxEn = genBus.txValid;
      srcTxEr = 1'b0;
    end
    else
    begin
      srcTxd = macTxd;
      srcTxEn = macTxEn;
      srcTxEr = macTxEr;
    end
  end

  // Data moves one word per link clock; the clock rate sets the speed.
  always_ff @(posedge linkClk or negedge nrst)
  begin
    if (!nrst)
    begin
      lineTxd <= 8'h00;
      lineTxEn <= 1'b0;
      lineTxEr <= 1'b0;
    end
    else if (loopLink)
    begin
      lineTxd <= 8'h00;
      lineTxEn <= 1'b0;
      lineTxEr <= 1'b0;
    end
    else
    begin
      lineTxd <= srcTxd;
      lineTxEn <= srcTxEn;
      lineTxEr <= srcTxEr;
    end
  end

  always_ff @(posedge linkClk or negedge nrst)
  begin
    if (!nrst)
    begin
      macRxd <= 8'h00;
      macRxDv <= 1'b0;
      macRxEr <= 1'b0;
    end
    else if (loopLink)
    begin
      macRxd <= srcTxd;
      macRxDv <= srcTxEn;
      macRxEr <= srcTxEr;
    end
    else
    begin
      macRxd <= lineRxd;
      macRxDv <= lineRxDv;
      macRxEr <= lineRxEr;
    end
  end

  // ==========================================================================
  // Receive monitor (link clock)
  // ==========================================================================
  // A packet counts at the end of its valid window, an error at the start of
  // each error burst. Each event flips a toggle for the crossing back.
  logic prevDv_q, prevEr_q, pktToggle_q, errToggle_q;

  always_ff @(posedge linkClk or negedge nrst)
  begin
    if (!nrst)
    begin
      prevDv_q <= 1'b0;
      prevEr_q <= 1'b0;
      pktToggle_q <= 1'b0;
      errToggle_q <= 1'b0;
    end
    else
    begin
      prevDv_q <= macRxDv;
      prevEr_q <= macRxEr;
      if (prevDv_q && !macRxDv)
      begin
        pktToggle_q <= ~pktToggle_q;
      end
      if (!prevEr_q && macRxEr)
      begin
        errToggle_q <= ~errToggle_q;
      end
    end
  end

  // ==========================================================================
  // Crossing from the link clock to the system clock
  // ==========================================================================
  // Toggles are decoded on the second and third stages only. Events closer
  // together than about two system clocks merge; that bounds the counter's
  // accuracy for closely spaced packet ends and error bursts alike at the fastest link rate.
  logic [2:0] backMeta_q, backSync_q, backPrev_q, backEdge;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      backMeta_q <= 3'h0;
      backSync_q <= 3'h0;
      backPrev_q <= 3'h0;
    end
    else
    begin
      backMeta_q <= {genBus.doneToggle, errToggle_q, pktToggle_q};
      backSync_q <= backMeta_q;
      backPrev_q <= backSync_q;
    end
  end

  assign backEdge = backSync_q ^ backPrev_q;
  assign pktSeen = backEdge[0];
  assign errSeen = backEdge[1];
  assign doneSeen = backEdge[2];

endmodule

// ### pst_self_test_chk.sv
// Port-level concurrent checks of the packet self test engine.
`timescale 1ns/1ps
module pst_self_test_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic linkClk,
  input wire logic [4:0] mgmtAddr,
  input wire logic mgmtWrEn,
  input wire logic [15:0] mgmtWrData,
  input wire logic mgmtRdEn,
  input wire logic [15:0] mgmtRdData,
  input wire logic lineTxEn,
  input wire logic macRxDv
);
  // ==========
  // Shadows
  // ==========
  logic [15:0] c1_q, c2_q;
  logic lb_q, cntOn_q, seen_q;
  logic [10:0] run_q, gap_q;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      c1_q <= 16'h0000;
      c2_q <= 16'h0000;
      lb_q <= 1'b0;
      cntOn_q <= 1'b0;
    end
    else if (mgmtWrEn)
    begin
      if (mgmtAddr == 5'h19) c1_q <= mgmtWrData;
      if (mgmtAddr == 5'h1a) c2_q <= mgmtWrData & 16'hf800;
      if (mgmtAddr == 5'h00) lb_q <= mgmtWrData[14];
      if (mgmtAddr == 5'h1a && mgmtWrData[15]) cntOn_q <= 1'b1;
    end
  end
  // The gap count saturates so that idle time between runs cannot wrap.
  always_ff @(posedge linkClk or negedge nrst)
  begin
    if (!nrst)
    begin
      run_q <= 11'h000;
      gap_q <= 11'h000;
      seen_q <= 1'b0;
    end
    else
    begin
      run_q <= lineTxEn ? run_q + 11'h001 : 11'h000;
      gap_q <= lineTxEn ? 11'h000 : (&gap_q ? gap_q : gap_q + 11'h001);
      seen_q <= seen_q | (!lineTxEn && run_q != 11'h000);
    end
  end
  // ==========
  // Assertions
  // ==========
  AST_CFG2_BACK: assert property (@(posedge sys_clk) disable iff (!nrst)
    mgmtRdEn && mgmtAddr == 5'h1a |=> mgmtRdData == c2_q) else $error("cfg two readback");
  AST_CTRL_BACK: assert property (@(posedge sys_clk) disable iff (!nrst)
    mgmtRdEn && mgmtAddr == 5'h00 |=> mgmtRdData == {1'b0, lb_q, 14'h0000})
    else $error("basic control readback");
  AST_CFG1_BACK: assert property (@(posedge sys_clk) disable iff (!nrst)
    mgmtRdEn && mgmtAddr == 5'h19 |=> (mgmtRdData & 16'hb7ff) == (c1_q & 16'hb4ff))
    else $error("cfg one readback");
  AST_CLEAR_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
    mgmtRdEn && mgmtAddr == 5'h19 |=> !mgmtRdData[14]) else $error("clear bit reads one");
  AST_IDLE_CNT: assert property (@(posedge sys_clk) disable iff (!nrst)
    mgmtRdEn && mgmtAddr == 5'h18 && !cntOn_q |=> mgmtRdData == 16'h0000)
    else $error("count moved while never enabled");
  AST_LEN: assert property (@(posedge linkClk) disable iff (!nrst)
    $fell(lineTxEn) |-> run_q == 11'd60 || run_q == 11'd1514) else $error("frame length");
  AST_GAP: assert property (@(posedge linkClk) disable iff (!nrst)
    $rose(lineTxEn) && seen_q |-> gap_q >= 11'd12) else $error("gap too short");
  AST_SIDES: assert property (@(posedge linkClk) disable iff (!nrst)
    !(lineTxEn && macRxDv)) else $error("line and receive side both active");
  cover property (@(posedge linkClk) $fell(lineTxEn));
  cover property (@(posedge linkClk) $fell(macRxDv));
  cover property (@(posedge sys_clk) mgmtWrEn && mgmtAddr == 5'h19 && mgmtWrData[11]);
endmodule
bind pst_self_test pst_self_test_chk pst_self_test_chk_inst (.sys_clk, .nrst, .linkClk,
  .mgmtAddr, .mgmtWrEn, .mgmtWrData, .mgmtRdEn, .mgmtRdData, .lineTxEn, .macRxDv);

// ### pst_link_model.sv
// Behavioural MAC and line partner of the packet self test engine.
`timescale 1ns/1ps
module pst_link_model (
  input wire logic linkClk,
  input wire logic go,
  input wire logic [7:0] nFrames,
  input wire logic withErr,
  input wire logic junk,
  output logic busy,
  output logic [7:0] lineRxd,
  output logic lineRxDv,
  output logic lineRxEr,
  output logic [7:0] macTxd,
  output logic macTxEn,
  output logic macTxEr
);
  // ==========
  // MAC side
  // ==========
  // Errored traffic while junk is up, so an ignored input carries data.
  always @(posedge linkClk)
  begin
    macTxd <= macTxd + 8'h01;
    macTxEn <= junk;
    macTxEr <= junk;
  end
  // ==========
  // Line side
  // ==========
  initial
  begin
    {busy, lineRxDv, lineRxEr, macTxEn, macTxEr} = 5'h00;
    lineRxd = 8'h00;
    macTxd = 8'h00;
    forever
    begin
      @(posedge linkClk);
      if (go === 1'b1)
      begin
        busy <= 1'b1;
        repeat (nFrames)
        begin
          for (int i = 0; i < 8; i++)
          begin
            lineRxDv <= 1'b1;
            lineRxd <= 8'h10 + 8'(i);
            lineRxEr <= withErr && i == 3;
            @(posedge linkClk);
          end
          lineRxDv <= 1'b0;
          lineRxEr <= 1'b0;
          lineRxd <= ~lineRxd;
          repeat (6) @(posedge linkClk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// ### pst_self_test_bench.sv
// Self-checking testbench of the packet self test engine.
`timescale 1ns/1ps
module pst_self_test_bench;
  logic sys_clk = 1'b0, linkClk = 1'b0, nrst = 1'b0;
  logic [4:0] mgmtAddr = 5'h00;
  logic mgmtWrEn = 1'b0, mgmtRdEn = 1'b0;
  logic [15:0] mgmtWrData = 16'h0000, mgmtRdData;
  logic [7:0] macTxd, macRxd, lineTxd, lineRxd, d, pat = 8'h00, nF = 8'h00;
  logic macTxEn, macTxEr, macRxDv, macRxEr, lineTxEn, lineTxEr, lineRxDv, lineRxEr;
  logic go = 1'b0, er = 1'b0, junk = 1'b0, busy, lb = 1'b0, prbs = 1'b0, v;
  logic [8:0] ps = 9'h1ff;
  logic [9:0] rxPrev;
  logic [16:0] nx;
  logic [4:0] adr [5] = '{5'h00, 5'h18, 5'h19, 5'h1a, 5'h05};
  int curLen = 0, lenQ = 0, gap = 0, gapQ = 0, nFrm = 0, bad = 0;
  int n_errors = 0, checked = 0;
  always #10 sys_clk = ~sys_clk;
  always #24 linkClk = ~linkClk;
  pst_self_test pst_self_test_inst (.sys_clk, .nrst, .linkClk, .mgmtAddr, .mgmtWrEn,
    .mgmtWrData, .mgmtRdEn, .mgmtRdData, .macTxd, .macTxEn, .macTxEr, .macRxd, .macRxDv,
    .macRxEr, .lineTxd, .lineTxEn, .lineTxEr, .lineRxd, .lineRxDv, .lineRxEr);
  pst_link_model pst_link_model_inst (.linkClk, .go, .nFrames(nF), .withErr(er), .junk,
    .busy, .lineRxd, .lineRxDv, .lineRxEr, .macTxd, .macTxEn, .macTxEr);
  // ==========
  // Helpers
  // ==========
  function automatic logic [16:0] nextByte(input logic [8:0] s0);
    logic [8:0] s;
    logic [7:0] b;
    s = s0;
    b = 8'h00;
    repeat (8)
    begin
      b = {b[6:0], s[8] ^ s[4]};
      s = {s[7:0], b[0]};
    end
    return {b, s};
  endfunction
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] w);
    @(posedge sys_clk);
    mgmtAddr <= a;
    mgmtWrData <= w;
    mgmtWrEn <= 1'b1;
    @(posedge sys_clk);
    mgmtWrEn <= 1'b0;
  endtask
  task rd(input logic [4:0] a, output logic [15:0] r);
    @(posedge sys_clk);
    mgmtAddr <= a;
    mgmtRdEn <= 1'b1;
    @(posedge sys_clk);
    mgmtRdEn <= 1'b0;
    #1 r = mgmtRdData;
  endtask
  task rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] r;
    rd(a, r);
    cmp(r, e);
  endtask
  task send(input logic [7:0] n, input logic e);
    @(posedge sys_clk);
    nF <= n;
    er <= e;
    go <= 1'b1;
    wait (busy === 1'b1);
    @(posedge sys_clk);
    go <= 1'b0;
    wait (busy === 1'b0);
    repeat (10) @(posedge sys_clk);
  endtask
  // Junk MAC traffic rides on the first frame only, while the generator owns the path.
  task gen(input logic [15:0] c1, input logic [15:0] c2, input logic l, input int nf,
    input int ln, input int gp);
    int k;
    logic [15:0] r;
    {lb, prbs, pat} = {l, c1[10], c1[7:0]};
    {nFrm, gapQ, lenQ} = '0;
    wr(5'h00, {1'b0, l, 14'h0000});
    wr(5'h1a, c2);
    wr(5'h19, c1);
    wait (curLen == 3);
    @(posedge sys_clk);
    junk <= 1'b1;
    wait (nFrm >= 1);
    @(posedge sys_clk);
    junk <= 1'b0;
    if (nf == 0)
    begin
      wait (nFrm >= 3);
      wr(5'h19, c1 & 16'hf7ff);
    end
    k = 0;
    do
    begin
      rd(5'h19, r);
      k++;
    end
    while (r[11] !== 1'b0 && k < 60000);
    repeat (400) @(posedge sys_clk);
    cmp(r, c1 & 16'hf7ff);
    k = nFrm;
    repeat (400) @(posedge sys_clk);
    cmp(nFrm, (nf == 0) ? k : nf);
    cmp(lenQ, ln);
    if (nf != 1) cmp(gapQ, gp);
    cmp(bad, 0);
  endtask
  task conclude;
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========
  // Frame monitor
  // ==========
  always @(negedge linkClk)
  begin
    v = lb ? macRxDv : lineTxEn;
    d = lb ? macRxd : lineTxd;
    if (lb && (lineTxEn !== 1'b0 || macRxEr !== 1'b0)) bad++;
    if (lineTxEr !== 1'b0) bad++;
    if (busy === 1'b1 && {macRxDv, macRxEr, macRxd} !== rxPrev) bad++;
    rxPrev = {lineRxDv, lineRxEr, lineRxd};
    if (v === 1'b1)
    begin
      if (curLen == 0 && nFrm > 0) gapQ = gap;
      nx = nextByte(ps);
      if (d !== (prbs ? nx[16:9] : pat)) bad++;
      if (prbs) ps = nx[8:0];
      curLen++;
      gap = 0;
    end
    else
    begin
      if (curLen > 0) nFrm++;
      if (curLen > 0) lenQ = curLen;
      curLen = 0;
      gap++;
    end
  end
  // ==========
  // Tests
  // ==========
  initial
  begin
    #2000000;
    n_errors++;
    conclude;
  end
  initial
  begin
    repeat (4) @(posedge linkClk);
    @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) rdc(adr[i], 16'h0000);
    wr(5'h05, 16'hffff);
    rdc(5'h05, 16'h0000);
    send(8'd3, 1'b0);
    rdc(5'h18, 16'h0000);
    wr(5'h1a, 16'h8000);
    send(8'd3, 1'b0);
    rdc(5'h18, 16'h0003);
    wr(5'h1a, 16'hc000);
    rdc(5'h18, 16'h0000);
    wr(5'h19, 16'hc000);
    wr(5'h1a, 16'h8000);
    rdc(5'h18, 16'h0000);
    send(8'd2, 1'b1);
    rdc(5'h18, 16'h0002);
    cmp(bad, 0);
    for (int c = 4; c < 8; c++)
    begin
      wr(5'h1a, 16'(c << 11));
      rdc(5'h1a, 16'(c << 11));
    end
    gen(16'h0c00, 16'h1000, 1'b1, 10, 60, 12);
    gen(16'h28a5, 16'h0800, 1'b0, 1, 1514, 0);
    gen(16'h185a, 16'h1000, 1'b0, 10, 60, 1200);
    gen(16'h0833, 16'h1800, 1'b0, 100, 60, 12);
    gen(16'h0877, 16'h0000, 1'b0, 0, 60, 12);
    conclude;
  end
endmodule
